// ---- src/dws_pkg.sv ----
// Shared types and constants for the doubleword store execution block
`default_nettype none
package dws_pkg;
  // ----------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------
  localparam int          DWS_XLEN     = 64;
  localparam int          DWS_IMM_W    = 16;
  localparam int          DWS_UNITS    = 4;
  localparam int          DWS_BYTES    = 8;
  localparam logic [2:0]  DWS_LANE_TOP = 3'h7;
  localparam logic [7:0]  DWS_BE_ALL   = 8'hff;
  localparam logic [63:0] DWS_WB_PASS  = 64'h1;
  localparam logic [63:0] DWS_WB_FAIL  = 64'h0;
  localparam logic        DWS_FLAG_RST = 1'h0;

  // ----------------------------------------------------------------
  // Operations and exception causes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DWS_OP_PLAIN,
    DWS_OP_COND,
    DWS_OP_COP,
    DWS_OP_LEFT
  } dws_op_t;

  typedef enum logic [1:0] {
    DWS_EXC_NONE,
    DWS_EXC_ADDR,
    DWS_EXC_COPU,
    DWS_EXC_RSVD
  } dws_exc_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    dws_op_t     op;
    logic [1:0]  unit;
    logic [63:0] base;
    logic [15:0] offset;
    logic [63:0] src;
  } dws_req_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic [7:0]  be;
  } dws_mem_t;
endpackage
`default_nettype wire

// ---- src/dws_store_exec.sv ----
// Doubleword store execution: conditional, plain, coprocessor and store-left
`default_nettype none

// Functional notes
// - Conditional store writes all 64 source bits only while link flag is set.
// - Conditional store writes link flag, zero-extended, back to source register.
// - Privileged system coprocessor events may also fail the conditional store.
// - Any exception between linked load and conditional store fails it.
// - Effective address is base plus sign-extended 16-bit displacement.
// - Nonzero low three address bits raise Address Error, no write, for every kind except store-left; coprocessor unit 0 or unusable unit traps first.
// - Plain store writes the full 64-bit source register unconditionally.
// - Coprocessor store takes its 64-bit data from the selected unit 1..3.
// - Coprocessor store to a unit not marked usable raises Coprocessor Unusable.
// - Coprocessor store for unit 0 is decoded as another instruction; this block raises DWS_EXC_RSVD for it, no write.
// - Store-left writes the top source bytes into the containing aligned doubleword.
// - Store-left lanes follow low three address bits and endian mode.
// - Conditional and plain stores raise only their listed exception kinds.
// - Coherent store by another agent into the linked block fails the store.
module dws_store_exec
  import dws_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_req_valid,
  input  wire dws_req_t             i_req,
  input  wire logic [3:0][63:0]     i_cop_data,
  input  wire logic [3:0]           i_cop_usable,
  input  wire logic                 i_big_endian,
  input  wire logic                 i_linked_load,
  input  wire logic                 i_exception,
  input  wire logic                 i_priv_event,
  input  wire logic                 i_snoop_hit,
  output logic                      o_mem_valid,
  output var dws_mem_t              o_mem,
  output logic                      o_wb_valid,
  output logic [63:0]               o_wb_data,
  output logic                      o_exc_valid,
  output var dws_exc_t              o_exc,
  output logic                      o_link_flag
);

  // ----------------------------------------------------------------
  // Address and decode
  // ----------------------------------------------------------------
  logic [63:0] ea;
  logic        misal;
  logic [2:0]  lane;
  logic [5:0]  left_sh;
  logic        is_cond;
  logic        fail_ext;
  logic        flag_eff;
  dws_exc_t    exc_now;

  assign ea       = i_req.base + {{48{i_req.offset[15]}}, i_req.offset};
  // Only the aligned kinds trap on these bits; store-left never does
  assign misal    = |ea[2:0];
  assign lane     = ea[2:0] ^ {3{i_big_endian}};
  assign left_sh  = {DWS_LANE_TOP - lane, 3'h0};
  assign is_cond  = i_req_valid && (i_req.op == DWS_OP_COND);
  // Same-cycle failure events are folded in so a store in that cycle fails
  assign fail_ext = i_exception || i_priv_event || i_snoop_hit;
  assign flag_eff = o_link_flag && !fail_ext;

  // Translation faults come from the memory side; only these kinds are ours
  always_comb
  begin
    exc_now = DWS_EXC_NONE;
    if (i_req.op == DWS_OP_COP && i_req.unit == 2'h0)
      exc_now = DWS_EXC_RSVD;
    else if (i_req.op == DWS_OP_COP && !i_cop_usable[i_req.unit])
      exc_now = DWS_EXC_COPU;
    else if (i_req.op != DWS_OP_LEFT && misal)
      exc_now = DWS_EXC_ADDR;
  end

  // ----------------------------------------------------------------
  // Link flag
  // ----------------------------------------------------------------
  // A linked load in the same cycle as a clearing event wins: it is younger
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      o_link_flag <= DWS_FLAG_RST;
    else if (i_linked_load)
      o_link_flag <= 1'h1;
    else if (fail_ext || is_cond)
      o_link_flag <= 1'h0;
  end

  // ----------------------------------------------------------------
  // Memory write port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_mem_valid <= 1'h0;
      o_mem       <= '0;
    end
    else
    begin
      o_mem_valid <= 1'h0;
      if (i_req_valid && exc_now == DWS_EXC_NONE)
      begin
        o_mem.addr <= ea;
        o_mem.be   <= DWS_BE_ALL;
        case (i_req.op)
          DWS_OP_PLAIN:
          begin
            o_mem_valid <= 1'h1;
            o_mem.data  <= i_req.src;
          end
          DWS_OP_COND:
          begin
            o_mem_valid <= flag_eff;
            o_mem.data  <= i_req.src;
          end
          DWS_OP_COP:
          begin
            o_mem_valid <= 1'h1;
            o_mem.data  <= i_cop_data[i_req.unit];
          end
          DWS_OP_LEFT:
          begin
            // Lanes 0..lane of the aligned doubleword get the top bytes
            o_mem_valid <= 1'h1;
            o_mem.addr  <= {ea[63:3], 3'h0};
            o_mem.data  <= i_req.src >> left_sh;
            o_mem.be    <= DWS_BE_ALL >> (DWS_LANE_TOP - lane);
          end
          default:
          begin
            o_mem_valid <= 1'h0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writeback and exceptions
  // ----------------------------------------------------------------
  // Result word stands until the next conditional store
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_wb_valid <= 1'h0;
      o_wb_data  <= DWS_WB_FAIL;
    end
    else
    begin
      o_wb_valid <= is_cond && exc_now == DWS_EXC_NONE;
      if (is_cond)
        o_wb_data <= flag_eff ? DWS_WB_PASS : DWS_WB_FAIL;
    end
  end

  // Cause code drops back to none on an idle cycle, so it never goes stale
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_exc_valid <= 1'h0;
      o_exc       <= DWS_EXC_NONE;
    end
    else
    begin
      o_exc_valid <= i_req_valid && exc_now != DWS_EXC_NONE;
      o_exc       <= i_req_valid ? exc_now : DWS_EXC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cond_req;
    i_req_valid && i_req.op == DWS_OP_COND && !misal && !i_linked_load;
  endsequence

  sequence s_snooped;
    i_snoop_hit && !i_linked_load;
  endsequence

  sequence s_plain_req;
    i_req_valid && i_req.op == DWS_OP_PLAIN && !misal;
  endsequence

  cond_pass_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_cond_req ##0 flag_eff |=> o_mem_valid && o_mem.data == $past(i_req.src)
      && o_wb_data == 64'h1)
    else $error("conditional store did not pass");

  cond_fail_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_cond_req ##0 !o_link_flag |=> !o_mem_valid && o_wb_valid && o_wb_data == 64'h0)
    else $error("conditional store did not fail");

  snoop_fail_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_snooped ##1 s_cond_req |=> !o_mem_valid && o_wb_data == 64'h0)
    else $error("store after snoop hit succeeded");

  exc_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_exception && !i_linked_load |=> !o_link_flag)
    else $error("exception left link flag set");

  addr_err_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op != DWS_OP_COP && i_req.op != DWS_OP_LEFT && misal
      |=> o_exc_valid && o_exc == DWS_EXC_ADDR && !o_mem_valid && !o_wb_valid)
    else $error("misaligned store not refused");

  ea_sum_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op == DWS_OP_PLAIN && !misal
      |=> o_mem_valid && o_mem.addr == $past(i_req.base)
        + {{48{$past(i_req.offset[15])}}, $past(i_req.offset)})
    else $error("effective address wrong");

  cop_unuse_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op == DWS_OP_COP && i_req.unit != 2'h0
      && !i_cop_usable[i_req.unit] |=> o_exc == DWS_EXC_COPU && !o_mem_valid)
    else $error("unusable coprocessor not trapped");

  cop_zero_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op == DWS_OP_COP && i_req.unit == 2'h0
      |=> o_exc_valid && o_exc == DWS_EXC_RSVD)
    else $error("unit zero not reserved");

  cop_data_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op == DWS_OP_COP && !misal && i_req.unit != 2'h0
      && i_cop_usable[i_req.unit]
      |=> o_mem_valid && o_mem.data == $past(i_cop_data[i_req.unit]))
    else $error("coprocessor data wrong");

  left_full_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op == DWS_OP_LEFT && lane == 3'h7
      |=> o_mem.be == 8'hff && o_mem.data == $past(i_req.src))
    else $error("store-left full lane wrong");

  left_one_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op == DWS_OP_LEFT && lane == 3'h0
      |=> o_mem.be == 8'h01 && o_mem.data[7:0] == $past(i_req.src[63:56]))
    else $error("store-left single lane wrong");

  idle_quiet_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !i_req_valid |=> !o_mem_valid && !o_wb_valid && !o_exc_valid)
    else $error("output without request");

  // ----------------------------------------------------------------
  // Link flag, writeback, write port and cause code checks
  // ----------------------------------------------------------------
  // A same-cycle linked load wins over every clear, so antecedents exclude it
  // Flag checks look one edge ahead only; longer holds are covered step by step

  plain_data_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_plain_req |=> o_mem_valid && o_mem.be == 8'hff && o_mem.data == $past(i_req.src))
    else $error("plain store data wrong");

  left_addr_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op == DWS_OP_LEFT
      |=> o_mem_valid && o_mem.addr[2:0] == 3'h0 && !o_exc_valid && !o_wb_valid)
    else $error("store-left address or trap wrong");

  cop_addr_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op == DWS_OP_COP && !misal && i_req.unit != 2'h0
      && i_cop_usable[i_req.unit] |=> o_mem.be == 8'hff && o_mem.addr == $past(ea))
    else $error("coprocessor store lanes wrong");

  wb_cond_only_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_req_valid && i_req.op != DWS_OP_COND |=> !o_wb_valid)
    else $error("writeback without conditional store");

  flag_set_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_linked_load |=> o_link_flag)
    else $error("linked load did not set flag");

  flag_used_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    is_cond && !i_linked_load |=> !o_link_flag)
    else $error("conditional store left flag set");

  priv_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_priv_event && !i_linked_load |=> !o_link_flag)
    else $error("privileged event left flag set");

  snoop_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_snooped |=> !o_link_flag)
    else $error("snoop hit left flag set");

  flag_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !i_linked_load && !fail_ext && !is_cond |=> o_link_flag == $past(o_link_flag))
    else $error("link flag changed without cause");

  exc_idle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !i_req_valid |=> o_exc == DWS_EXC_NONE)
    else $error("exception code without request");

endmodule
`default_nettype wire

// ---- tb/dws_mem_model.sv ----
// Memory side model: merges every write into one doubleword by lane
`default_nettype none
module dws_mem_model
  import dws_pkg::*;
(
  input  wire logic     i_clock,
  input  wire logic     i_sys_rst,
  input  wire logic     i_mem_valid,
  input  wire dws_mem_t i_mem,
  output logic [63:0]   o_word,
  output logic [7:0]    o_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // Stands for cached memory only, one access type
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_word  <= 64'h0;
      o_count <= 8'h0;
    end
    else if (i_mem_valid)
    begin
      o_count <= o_count + 8'h1;
      for (int b = 0; b < 8; b++)
      begin
        if (i_mem.be[b])
          o_word[8*b +: 8] <= i_mem.data[8*b +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the doubleword store execution block
`default_nettype none
module tb_top
  import dws_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             rq_v = 1'b0;
  dws_req_t         rq = '0;
  logic [3:0][63:0] cop_d = '0;
  logic [3:0]       cop_u = 4'h0;
  logic             big = 1'b0;
  logic [3:0]       ev = 4'h0;
  logic             mv, wv, xv, lf;
  dws_mem_t         mem;
  logic [63:0]      wb, word;
  logic [7:0]       cnt;
  dws_exc_t         exc;
  int               miscompares = 0;
  int               n_compared = 0;
  time              rq_end = 0;
  time              ev_end = 0;

  always #2.5 clk = ~clk;

  dws_store_exec u_dut (.i_clock(clk), .i_sys_rst(rst), .i_req_valid(rq_v), .i_req(rq),
    .i_cop_data(cop_d), .i_cop_usable(cop_u), .i_big_endian(big), .i_linked_load(ev[0]),
    .i_exception(ev[1]), .i_priv_event(ev[2]), .i_snoop_hit(ev[3]), .o_mem_valid(mv),
    .o_mem(mem), .o_wb_valid(wv), .o_wb_data(wb), .o_exc_valid(xv), .o_exc(exc),
    .o_link_flag(lf));
  dws_mem_model u_mem (.i_clock(clk), .i_sys_rst(rst), .i_mem_valid(mv), .i_mem(mem),
    .o_word(word), .o_count(cnt));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [79:0] g, input logic [79:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_exc(input dws_exc_t g, input dws_exc_t e, input string m);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, m, g, e);
    end
  endtask
  // Called at a falling edge; holds inputs across exactly one rising edge
  // A strobe that has just dropped gets one idle edge before it rises again
  task automatic pulse(input logic [3:0] k);
    if (ev_end == $time)
      @(negedge clk);
    ev = k;
    @(posedge clk);
    @(negedge clk);
    ev = 4'h0;
    ev_end = $time;
  endtask
  task automatic issue(input dws_op_t o, input logic [1:0] u, input logic [63:0] b,
                       input logic [15:0] f, input logic [63:0] s);
    if (rq_end == $time)
      @(negedge clk);
    rq = '{op: o, unit: u, base: b, offset: f, src: s};
    rq_v = 1'b1;
    @(posedge clk);
    @(negedge clk);
    rq_v = 1'b0;
    rq_end = $time;
  endtask
  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_cond();
    pulse(4'h1);
    chk_val(lf, 64'h1, "flag set");
    issue(DWS_OP_COND, 2'h0, 64'h1000, 16'h0008, 64'h0123_4567_89ab_cdef);
    chk_val({mv, mem.data}, {1'b1, 64'h0123_4567_89ab_cdef}, "cond write");
    chk_val(mem.addr, 64'h1008, "cond addr");
    chk_val({wv, wb}, {1'b1, 64'h1}, "cond pass");
    chk_val(lf, 64'h0, "flag used");
    // Next store one idle edge later, flag already consumed
    issue(DWS_OP_COND, 2'h0, 64'h1000, 16'h0008, 64'h5);
    chk_val({mv, wv, wb}, {2'b01, 64'h0}, "cond fail");
    chk_val(cnt, 64'h1, "one write");
    chk_val(word, 64'h0123_4567_89ab_cdef, "mem kept");
  endtask
  task automatic t_events();
    for (int k = 1; k < 4; k++)
    begin
      pulse(4'h1);
      pulse(4'h1 << k);
      issue(DWS_OP_COND, 2'h0, 64'h1000, 16'h0000, 64'h7);
      chk_val({mv, wv, wb}, {2'b01, 64'h0}, "event fail");
    end
  endtask
  task automatic t_plain();
    issue(DWS_OP_PLAIN, 2'h0, 64'h2000, 16'hfff8, 64'hfeed_0000_beef_1111);
    chk_val({mv, mem.be, mem.data}, {9'h1ff, 64'hfeed_0000_beef_1111}, "plain");
    chk_val(mem.addr, 64'h1ff8, "sext addr");
    issue(DWS_OP_PLAIN, 2'h0, 64'h2004, 16'h0000, 64'h1);
    chk_val({mv, xv}, 64'h1, "plain trap");
    chk_exc(exc, DWS_EXC_ADDR, "plain addr");
    pulse(4'h1);
    issue(DWS_OP_COND, 2'h0, 64'h2001, 16'h0000, 64'h1);
    chk_val({mv, wv, xv}, 64'h1, "cond trap");
  endtask
  task automatic t_cop();
    cop_d = {64'h3, 64'h2222, 64'h1111, 64'h0};
    cop_u = 4'h6;
    issue(DWS_OP_COP, 2'h1, 64'h4000, 16'h0010, 64'h0);
    chk_val({mv, mem.data}, {1'b1, 64'h1111}, "cop data");
    issue(DWS_OP_COP, 2'h3, 64'h4000, 16'h0000, 64'h0);
    chk_exc(exc, DWS_EXC_COPU, "cop unusable");
    issue(DWS_OP_COP, 2'h0, 64'h4000, 16'h0000, 64'h0);
    chk_exc(exc, DWS_EXC_RSVD, "cop unit0");
    issue(DWS_OP_COP, 2'h2, 64'h4002, 16'h0000, 64'h0);
    chk_exc(exc, DWS_EXC_ADDR, "cop align");
    chk_val({mv, xv}, 64'h1, "cop no write");
  endtask
  task automatic t_left();
    logic [2:0] ln;
    for (int m = 0; m < 2; m++)
    begin
      for (int a = 0; a < 8; a++)
      begin
        big = m[0];
        issue(DWS_OP_LEFT, 2'h0, 64'h3000 + a, 16'h0000, 64'h8877_6655_4433_2211);
        ln = a[2:0] ^ {3{m[0]}};
        chk_val(mem.addr, 64'h3000, "left addr");
        chk_val({xv, mv, mem.be}, {2'b01, 8'hff >> (7 - ln)}, "left be");
        chk_val(mem.data, 64'h8877_6655_4433_2211 >> (8 * (7 - ln)), "left data");
      end
    end
  endtask

  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_cond();
    t_events();
    t_plain();
    t_cop();
    t_left();
    close_out();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
